/* File: verilog/qpo_pkg.sv */
package qpo_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ          = 250;
    localparam int EDGE_GAP_SLOW_NS = 400;   // coarse resolution variant
    localparam int EDGE_GAP_FAST_NS = 200;   // finer resolution variant
    localparam int ERR_PULSE_NS     = 400;
    localparam int LAG_MAX_NS       = 1000;

    // least times round up, the longest time rounds down
    localparam int EDGE_GAP_SLOW_CYC = (EDGE_GAP_SLOW_NS * CLK_MHZ + 999) / 1000;
    localparam int EDGE_GAP_FAST_CYC = (EDGE_GAP_FAST_NS * CLK_MHZ + 999) / 1000;
    localparam int ERR_PULSE_CYC     = (ERR_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int LAG_MAX_CYC       = (LAG_MAX_NS * CLK_MHZ) / 1000;

    // ------------------------------------------------------------------
    // backlog of steps that can still be paid off inside the lag limit
    // ------------------------------------------------------------------
    localparam int BACKLOG_MAX_SLOW = LAG_MAX_CYC / EDGE_GAP_SLOW_CYC;
    localparam int BACKLOG_MAX_FAST = LAG_MAX_CYC / EDGE_GAP_FAST_CYC;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] PHASE_IDX_RST = 2'h0;

    typedef enum logic [1:0] {
        QPO_TRACK,
        QPO_FAULT
    } qpo_state_e;

endpackage : qpo_pkg

/* File: verilog/qpo_interval_timer.sv */
module qpo_interval_timer #(
    parameter int W = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_count,
    output logic              o_done
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (i_load) begin
            cnt_d = i_count;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - W'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // done while idle, so the first edge after a quiet spell goes out at once
    assign o_done = (cnt_q == '0);

endmodule : qpo_interval_timer

/* File: verilog/qpo_quadrature_out.sv */
// Summary of operation
// - two differential square phases, quarter period apart
// - inward travel: A leads; outward: B leads
// - edges tracked only below speed limit
// - emitted count lags position at most 1 us
// - edges spaced by min_edge_interval per resolution
// - origin phase pulses while passing reference zone, but stays off during error
// - overspeed or disturbance enters error output pattern
// - error pulses last error_pulse_min_width or longer
module qpo_quadrature_out #(
    parameter int  BL_W       = 8,
    parameter bit  HAS_ORIGIN = 1'b1
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_step,
    input  wire logic i_step_inward,
    input  wire logic i_res_fine,
    input  wire logic i_disturb,
    input  wire logic i_origin_zone,
    output logic      o_phase_a_out_p,
    output logic      o_phase_a_out_n,
    output logic      o_phase_b_out_p,
    output logic      o_phase_b_out_n,
    output logic      o_origin_mark_out_p,
    output logic      o_origin_mark_out_n,
    output logic      o_error
);

    // ------------------------------------------------------------------
    // constants sized to the logic they meet
    // ------------------------------------------------------------------
    localparam int TMR_W = 8;
    localparam logic [TMR_W-1:0] GAP_SLOW = TMR_W'(qpo_pkg::EDGE_GAP_SLOW_CYC);
    localparam logic [TMR_W-1:0] GAP_FAST = TMR_W'(qpo_pkg::EDGE_GAP_FAST_CYC);
    localparam logic [TMR_W-1:0] ERR_GAP  = TMR_W'(qpo_pkg::ERR_PULSE_CYC);
    localparam logic [BL_W-1:0]  BL_SLOW  = BL_W'(qpo_pkg::BACKLOG_MAX_SLOW);
    localparam logic [BL_W-1:0]  BL_FAST  = BL_W'(qpo_pkg::BACKLOG_MAX_FAST);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [BL_W-1:0] qpo_mag(input logic signed [BL_W-1:0] v);
        qpo_mag = v[BL_W-1] ? BL_W'(-v) : BL_W'(v);
    endfunction : qpo_mag

    // index 0..3 walks 00,10,11,01 as {a,b}: counting up makes A lead
    function automatic logic [1:0] qpo_gray(input logic [1:0] idx);
        qpo_gray = {idx[1] ^ idx[0], idx[1]};
    endfunction : qpo_gray

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    qpo_pkg::qpo_state_e     st_q;
    qpo_pkg::qpo_state_e     st_d;
    logic signed [BL_W-1:0]  bl_q;
    logic signed [BL_W-1:0]  bl_d;
    logic [1:0]              idx_q;
    logic [1:0]              idx_d;
    logic                    a_q;
    logic                    a_d;
    logic                    b_q;
    logic                    b_d;
    logic                    z_q;
    logic                    z_d;
    logic                    err_q;
    logic                    err_d;
    logic                    tmr_load;
    logic [TMR_W-1:0]        tmr_cnt;
    logic                    tmr_done;
    logic signed [BL_W-1:0]  bl_in;
    logic [BL_W-1:0]         bl_lim;
    logic                    overspeed;
    logic                    a_p_d;
    logic                    a_n_d;
    logic                    b_p_d;
    logic                    b_n_d;
    logic                    z_p_d;
    logic                    z_n_d;

    qpo_interval_timer #(
        .W (TMR_W)
    ) u_gap (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_load  (tmr_load),
        .i_count (tmr_cnt),
        .o_done  (tmr_done)
    );

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        st_d     = st_q;
        bl_d     = bl_q;
        idx_d    = idx_q;
        a_d      = a_q;
        b_d      = b_q;
        err_d    = err_q;
        tmr_load = 1'b0;
        tmr_cnt  = i_res_fine ? GAP_FAST : GAP_SLOW;
        // inward step counts up the index, so A leads when retracting
        bl_in    = bl_q;
        if (i_step) begin
            bl_in = i_step_inward ? bl_q + BL_W'(1) : bl_q - BL_W'(1);
        end
        // a backlog beyond what the gap lets us repay within the lag limit
        // means the spindle outruns the output
        bl_lim    = i_res_fine ? BL_FAST : BL_SLOW;
        overspeed = qpo_mag(bl_in) > bl_lim;

        case (st_q)
            qpo_pkg::QPO_TRACK: begin
                bl_d = bl_in;
                if (overspeed || i_disturb) begin
                    st_d     = qpo_pkg::QPO_FAULT;
                    err_d    = 1'b1;
                    bl_d     = '0;
                    a_d      = ~a_q;
                    b_d      = ~b_q;
                    tmr_load = 1'b1;
                    tmr_cnt  = ERR_GAP;
                end else if (tmr_done && bl_in != '0) begin
                    idx_d    = bl_in[BL_W-1] ? idx_q - 2'h1 : idx_q + 2'h1;
                    bl_d     = bl_in[BL_W-1] ? bl_in + BL_W'(1) : bl_in - BL_W'(1);
                    {a_d, b_d} = qpo_gray(idx_d);
                    tmr_load = 1'b1;
                end
            end
            qpo_pkg::QPO_FAULT: begin
                // both phases flip together: no legal quadrature step looks
                // like this, so the receiver can spot it
                bl_d = '0;
                if (tmr_done) begin
                    if (i_disturb || overspeed) begin
                        a_d      = ~a_q;
                        b_d      = ~b_q;
                        tmr_load = 1'b1;
                        tmr_cnt  = ERR_GAP;
                    end else begin
                        // resume from the phase index left before the fault;
                        // position is lost and the receiver must re-home
                        st_d       = qpo_pkg::QPO_TRACK;
                        err_d      = 1'b0;
                        {a_d, b_d} = qpo_gray(idx_q);
                        tmr_load   = 1'b1;
                        tmr_cnt    = ERR_GAP;
                    end
                end
            end
            default: begin
                st_d  = qpo_pkg::QPO_TRACK;
                bl_d  = '0;
                err_d = 1'b0;
            end
        endcase

        z_d = HAS_ORIGIN && i_origin_zone && (st_d == qpo_pkg::QPO_TRACK);
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q  <= qpo_pkg::QPO_TRACK;
            bl_q  <= '0;
            idx_q <= qpo_pkg::PHASE_IDX_RST;
            a_q   <= 1'b0;
            b_q   <= 1'b0;
            z_q   <= 1'b0;
            err_q <= 1'b0;
        end else begin
            st_q  <= st_d;
            bl_q  <= bl_d;
            idx_q <= idx_d;
            a_q   <= a_d;
            b_q   <= b_d;
            z_q   <= z_d;
            err_q <= err_d;
        end
    end

    // ------------------------------------------------------------------
    // next values of the pin flops
    // ------------------------------------------------------------------
    always_comb begin
        // complement formed ahead of the flops so both legs move on one edge
        a_p_d = a_d;
        a_n_d = ~a_d;
        b_p_d = b_d;
        b_n_d = ~b_d;
        z_p_d = z_d;
        z_n_d = ~z_d;
    end

    // ------------------------------------------------------------------
    // differential outputs, each leg its own flop so both switch together
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_phase_a_out_p     <= 1'b0;
            o_phase_a_out_n     <= 1'b1;
            o_phase_b_out_p     <= 1'b0;
            o_phase_b_out_n     <= 1'b1;
            o_origin_mark_out_p <= 1'b0;
            o_origin_mark_out_n <= 1'b1;
            o_error             <= 1'b0;
        end else begin
            o_phase_a_out_p     <= a_p_d;
            o_phase_a_out_n     <= a_n_d;
            o_phase_b_out_p     <= b_p_d;
            o_phase_b_out_n     <= b_n_d;
            o_origin_mark_out_p <= z_p_d;
            o_origin_mark_out_n <= z_n_d;
            o_error             <= err_d;
        end
    end

endmodule : qpo_quadrature_out

/* File: verification/qpo_rx_model.sv */
module qpo_rx_model (
    input  wire logic          i_clk,
    input  wire logic          i_rst,
    input  wire logic          i_a,
    input  wire logic          i_b,
    input  wire logic          i_err,
    output logic signed [15:0] o_count,
    output logic [7:0]         o_dbl
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // receiver: two sync stages, then decode at the full clock rate
    // ------------------------------------------------------------------
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    always_ff @(posedge i_clk) begin
        s1_q <= {i_err, i_a, i_b};
        s2_q <= s1_q;
        if (i_rst) begin
            o_count <= 16'h0000;
            o_dbl   <= 8'h00;
        end else if (s1_q[2] || s2_q[2]) begin
            // the restore edge lands with the error fall, so both sides are skipped
        end else if (s1_q[1] != s2_q[1] && s1_q[0] != s2_q[0]) begin
            o_dbl <= o_dbl + 8'h01;
        end else if (s1_q[1] != s2_q[1]) begin
            o_count <= (s1_q[1] == !s2_q[0]) ? o_count - 16'h0001 : o_count + 16'h0001;
        end else if (s1_q[0] != s2_q[0]) begin
            o_count <= (s1_q[0] == s2_q[1]) ? o_count - 16'h0001 : o_count + 16'h0001;
        end
    end
endmodule : qpo_rx_model

/* File: verification/qpo_quadrature_out_sva.sv */
module qpo_quadrature_out_sva (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_step,
    input wire logic i_res_fine,
    input wire logic i_disturb,
    input wire logic i_origin_zone,
    input wire logic o_phase_a_out_p,
    input wire logic o_phase_a_out_n,
    input wire logic o_phase_b_out_p,
    input wire logic o_phase_b_out_n,
    input wire logic o_origin_mark_out_p,
    input wire logic o_origin_mark_out_n,
    input wire logic o_error
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    // ------------------------------------------------------------------
    // cycles since last phase change, cycles spent in error
    // ------------------------------------------------------------------
    logic [1:0] ab_q;
    logic [7:0] gap_q;
    logic [7:0] gap_d;
    logic [7:0] hi_q;
    logic [7:0] hi_d;
    logic       chg;
    always_comb begin
        chg   = {o_phase_a_out_p, o_phase_b_out_p} != ab_q;
        gap_d = chg ? 8'h01 : (gap_q == 8'hff ? gap_q : gap_q + 8'h01);
        hi_d  = o_error ? (hi_q == 8'hff ? hi_q : hi_q + 8'h01) : 8'h00;
    end
    always_ff @(posedge i_clk) begin
        ab_q  <= i_rst ? 2'h0 : {o_phase_a_out_p, o_phase_b_out_p};
        gap_q <= i_rst ? 8'hff : gap_d;
        hi_q  <= i_rst ? 8'h00 : hi_d;
    end
    a_pairs_complement: assert property ((o_phase_a_out_n != o_phase_a_out_p) &&
        (o_phase_b_out_n != o_phase_b_out_p) && (o_origin_mark_out_n != o_origin_mark_out_p))
        else $error("output pair not complementary");
    a_single_phase_edge: assert property (chg && !o_error && !$past(o_error)
        |-> {o_phase_a_out_p, o_phase_b_out_p} != ~ab_q) else $error("both phases moved");
    a_edge_gap_min: assert property (chg && !o_error
        |-> gap_q >= (i_res_fine ? 8'h32 : 8'h64)) else $error("edges too close");
    a_step_lag_bound: assert property (i_step && !o_error
        |-> ##[1:250] (chg || o_error)) else $error("step not emitted in time");
    a_err_both_flip: assert property ($rose(o_error)
        |-> {o_phase_a_out_p, o_phase_b_out_p} == ~ab_q) else $error("error entry wrong");
    a_disturb_err_next: assert property (i_disturb |=> o_error)
        else $error("disturbance not flagged");
    a_err_width_min: assert property ($fell(o_error) |-> hi_q >= 8'h64)
        else $error("error level too short");
    a_err_toggle_gap: assert property (chg && o_error && $past(o_error) |-> gap_q >= 8'h64)
        else $error("error pulse too short");
    a_origin_follows: assert property (o_origin_mark_out_p |-> $past(i_origin_zone))
        else $error("origin out of zone");
endmodule : qpo_quadrature_out_sva

bind qpo_quadrature_out qpo_quadrature_out_sva u_sva (.i_clk, .i_rst, .i_step, .i_res_fine,
    .i_disturb, .i_origin_zone, .o_phase_a_out_p, .o_phase_a_out_n, .o_phase_b_out_p,
    .o_phase_b_out_n, .o_origin_mark_out_p, .o_origin_mark_out_n, .o_error);

/* File: verification/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst, step, inw, fine, dis, zone, ap, an, bp, bn, zp, zn, err;
    logic signed [15:0] cnt;
    logic [7:0]         dbl;
    int miscompares = 0;
    int samples_checked = 0;
    always #2 clk = ~clk;
    qpo_quadrature_out u_dut (.i_clk(clk), .i_rst(rst), .i_step(step), .i_step_inward(inw),
        .i_res_fine(fine), .i_disturb(dis), .i_origin_zone(zone), .o_phase_a_out_p(ap),
        .o_phase_a_out_n(an), .o_phase_b_out_p(bp), .o_phase_b_out_n(bn),
        .o_origin_mark_out_p(zp), .o_origin_mark_out_n(zn), .o_error(err));
    qpo_rx_model u_rx (.i_clk(clk), .i_rst(rst), .i_a(ap), .i_b(bp), .i_err(err),
        .o_count(cnt), .o_dbl(dbl));
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] pins();
        return {9'h000, ap, an, bp, bn, zp, zn, err};
    endfunction : pins
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    // back-to-back steps, one per cycle, queued by the design up to its backlog limit
    task automatic steps(int n, logic d, logic f);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            step <= 1'b1;
            inw  <= d;
            fine <= f;
        end
        @(posedge clk);
        step <= 1'b0;
    endtask : steps
    task automatic wait_err(logic lvl, int lim);
        int k;
        k = 0;
        while (err !== lvl && k < lim) begin
            @(negedge clk);
            k++;
        end
        if (err !== lvl) begin
            miscompares++;
            final_report();
        end
    endtask : wait_err
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_inward();
        steps(2, 1'b1, 1'b0);
        @(negedge clk);
        chk("pins", 16'h004a, pins());
        repeat (110) @(negedge clk);
        chk("pins", 16'h0052, pins());
        chk("count", 16'hfffe, cnt);
        $display("done t_inward");
    endtask : t_inward
    task automatic t_outward();
        steps(4, 1'b0, 1'b1);
        repeat (250) @(negedge clk);
        chk("count", 16'h0002, cnt);
        $display("done t_outward");
    endtask : t_outward
    task automatic t_overflow();
        steps(5, 1'b1, 1'b0);
        wait_err(1'b1, 10);
        wait_err(1'b0, 300);
        repeat (60) @(negedge clk);
        chk("count", 16'h0002, cnt);
        $display("done t_overflow");
    endtask : t_overflow
    task automatic t_disturb();
        @(posedge clk);
        dis <= 1'b1;
        @(negedge clk);
        @(negedge clk);
        chk("error", 16'h0001, {15'h0000, err});
        steps(1, 1'b1, 1'b0);
        repeat (150) @(posedge clk);
        dis <= 1'b0;
        wait_err(1'b0, 300);
        repeat (60) @(negedge clk);
        chk("count", 16'h0002, cnt);
        chk("double", 16'h0000, {8'h00, dbl});
        $display("done t_disturb");
    endtask : t_disturb
    task automatic t_origin();
        @(posedge clk);
        zone <= 1'b1;
        repeat (2) @(negedge clk);
        chk("origin", 16'h0002, {14'h0000, zp, zn});
        @(posedge clk);
        zone <= 1'b0;
        repeat (2) @(negedge clk);
        chk("origin", 16'h0001, {14'h0000, zp, zn});
        $display("done t_origin");
    endtask : t_origin
    initial begin
        rst  = 1'b1;
        step = 1'b0;
        inw  = 1'b0;
        fine = 1'b0;
        dis  = 1'b0;
        zone = 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("pins", 16'h002a, pins());
        t_inward();
        t_outward();
        t_overflow();
        t_disturb();
        t_origin();
        final_report();
    end
endmodule : tb
